// *** verilog/wwdt_pkg.sv ***
package wwdt_pkg;
	// clock rates
	localparam int unsigned SYS_CLK_HZ = 125000000;
	localparam int unsigned RC_OSC_HZ = 32000;
	localparam int unsigned OSC_DIV_CYCLES = SYS_CLK_HZ / RC_OSC_HZ;
	localparam int OSC_DIV_W = 12;
	localparam logic [OSC_DIV_W-1:0] OSC_DIV_TERM = OSC_DIV_W'(OSC_DIV_CYCLES - 1);
	////////////////////////////////////////////////////////////////////////
	// base time-out of the prescaler alone, in microseconds
	localparam int unsigned BASE_TIMEOUT_US_SHORT = 1000;
	localparam int unsigned BASE_TIMEOUT_US_LONG = 4000;
	localparam int unsigned PRE_DIV_SHORT = BASE_TIMEOUT_US_SHORT * (RC_OSC_HZ / 1000) / 1000;
	localparam int unsigned PRE_DIV_LONG = BASE_TIMEOUT_US_LONG * (RC_OSC_HZ / 1000) / 1000;
	localparam int PRE_W = 7;
	localparam int PRE_SHIFT_SHORT = 5;
	localparam int PRE_SHIFT_LONG = 7;
	localparam logic [PRE_W-1:0] PRE_TERM_SHORT = PRE_W'(PRE_DIV_SHORT - 1);
	localparam logic [PRE_W-1:0] PRE_TERM_LONG = PRE_W'(PRE_DIV_LONG - 1);
	////////////////////////////////////////////////////////////////////////
	// postscaler: code n selects 2**n
	localparam int POST_W = 15;
	localparam int POST_CODE_W = 4;
	localparam logic [POST_W:0] POST_ONE = 16'h0001;
	// elapsed-time arithmetic width, prescale and postscale together
	localparam int ELAPSED_W = POST_W + PRE_W + 1;
	localparam logic [ELAPSED_W-1:0] ELAPSED_ONE = 23'h000001;
	localparam int WINDOW_QUARTER_SHIFT = 2;
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [0:0] {
		WWDT_RUN,
		WWDT_SAVE
	} wwdt_mode_t;
endpackage : wwdt_pkg

// *** verilog/wwdt_scaler.sv ***
`timescale 1ns/1ps
module wwdt_scaler #(
	parameter int W = 8
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic clr_i,
	input wire logic inc_i,
	input wire logic [W-1:0] term_i,
	output logic [W-1:0] count_o,
	output logic wrap_o
);
	import wwdt_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
	} wwdt_scaler_state_t;

	wwdt_scaler_state_t r_q;
	wwdt_scaler_state_t r_d;

	// wrap is combinational so the next stage steps in the same cycle
	assign wrap_o = inc_i && (r_q.cnt == term_i);
	assign count_o = r_q.cnt;

	always_comb
	begin
		r_d = r_q;
		if (clr_i)
			r_d.cnt = '0;
		else if (wrap_o)
			r_d.cnt = '0;
		else if (inc_i)
			r_d.cnt = r_q.cnt + W'(1);
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			r_q <= '0;
		else
			r_q <= r_d;
	end
endmodule : wwdt_scaler

// *** verilog/wwdt_top.sv ***
`timescale 1ns/1ps
// Behaviour
// - watchdog runs on low-power oscillator; enabling watchdog forces oscillator on.
// - prescaler divides 32 kHz by 32 or 128 per select bit.
// - prescaler alone gives 1 ms or 4 ms base time-out.
// - 4-bit postscaler field picks one of 16 ratios, 1:1 to 1:32768.
// - device reset or finished clock switch clears counter, prescaler, postscaler.
// - entering or leaving sleep/idle clears counter, prescaler, postscaler.
// - clear-watchdog instruction in normal execution clears all counts.
// - enabled watchdog counts in sleep/idle; time-out there wakes, no reset.
// - permanent-enable bit set keeps watchdog always enabled.
// - permanent-enable clear means watchdog runs only while soft enable set.
// - every device reset clears the soft enable bit.
// - window mode: clear before final quarter of period causes watchdog reset.
// - time-out sets flag; only software clears it.
// - prescale select 1 gives divide-by-128, 0 gives divide-by-32.
// - postscale code 1111 is 1:32768, 1110 is 1:16384, halving downward.
// - with permanent enable, clearing soft enable does nothing, oscillator stays.
// - window-disable bit 1 is non-window, 0 is window operation.
module wwdt_top (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic permanent_enable_bit_i,
	input wire logic window_disable_bit_i,
	input wire logic prescale_select_bit_i,
	input wire logic [wwdt_pkg::POST_CODE_W-1:0] postscale_select_field_i,
	input wire logic soft_enable_wr_i,
	input wire logic soft_enable_wdata_i,
	input wire logic timeout_flag_clr_i,
	input wire logic clear_watchdog_instr_i,
	input wire logic power_save_instr_i,
	input wire logic power_save_exit_i,
	input wire logic clk_switch_done_i,
	input wire logic device_reset_i,
	output logic low_power_rc_osc_en_o,
	output logic soft_enable_bit_o,
	output logic timeout_flag_o,
	output logic watchdog_reset_o,
	output logic wake_o,
	output logic power_save_o,
	output logic window_open_o
);
	import wwdt_pkg::*;

	typedef struct packed {
		wwdt_mode_t mode;
		logic soft_en;
		logic osc_en;
		logic flag;
		logic rst_pulse;
		logic wake_pulse;
		logic win_open;
	} wwdt_top_state_t;

	wwdt_top_state_t r_q;
	wwdt_top_state_t r_d;

	logic wd_enable;
	logic dev_reset_evt;
	logic in_run;
	logic clear_watchdog_instr_run;
	logic enter_save;
	logic leave_save;
	logic early_clear;
	logic timeout;
	logic cnt_clr;
	logic osc_tick;
	logic pre_tick;
	logic [PRE_W-1:0] pre_term;
	logic [PRE_W-1:0] pre_count;
	logic [POST_W-1:0] post_term;
	logic [POST_W-1:0] post_count;
	logic [POST_W:0] post_ratio;
	logic [ELAPSED_W-1:0] elapsed;
	logic [ELAPSED_W-1:0] period;
	logic [ELAPSED_W-1:0] window_start;
	logic window_open;

	////////////////////////////////////////////////////////////////////////
	// enable and event decode

	// soft enable only matters while the permanent bit is clear
	assign wd_enable = permanent_enable_bit_i || r_q.soft_en;
	// our own reset pulse counts as a device reset one cycle later
	assign dev_reset_evt = device_reset_i || r_q.rst_pulse;
	assign in_run = (r_q.mode == WWDT_RUN);
	assign clear_watchdog_instr_run = clear_watchdog_instr_i && in_run;
	assign enter_save = power_save_instr_i && in_run;
	assign leave_save = !in_run && (power_save_exit_i || timeout);
	assign timeout = pre_tick && (post_count == post_term);

	// disabled watchdog holds its counts at zero
	assign cnt_clr = !wd_enable
		|| dev_reset_evt
		|| clk_switch_done_i
		|| enter_save
		|| leave_save
		|| clear_watchdog_instr_run
		|| timeout;

	////////////////////////////////////////////////////////////////////////
	// oscillator tick, prescaler and postscaler

	// rc oscillator modelled as a tick every 1/32 kHz of system clock
	wwdt_scaler #(
		.W(OSC_DIV_W)
	) u_osc (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.clr_i(!r_q.osc_en),
		.inc_i(r_q.osc_en),
		.term_i(OSC_DIV_TERM),
		.count_o(),
		.wrap_o(osc_tick)
	);

	assign pre_term = prescale_select_bit_i ? PRE_TERM_LONG : PRE_TERM_SHORT;

	wwdt_scaler #(
		.W(PRE_W)
	) u_pre (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.clr_i(cnt_clr),
		.inc_i(osc_tick && wd_enable),
		.term_i(pre_term),
		.count_o(pre_count),
		.wrap_o(pre_tick)
	);

	// ratio 2**n; code 0 wraps on every prescaler tick
	assign post_ratio = POST_ONE << postscale_select_field_i;
	assign post_term = POST_W'(post_ratio - POST_ONE);

	wwdt_scaler #(
		.W(POST_W)
	) u_post (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.clr_i(cnt_clr),
		.inc_i(pre_tick),
		.term_i(post_term),
		.count_o(post_count),
		.wrap_o()
	);

	////////////////////////////////////////////////////////////////////////
	// window: elapsed oscillator ticks against three quarters of the period

	// powers of two, so elapsed is the two counts side by side
	always_comb
	begin
		if (prescale_select_bit_i)
		begin
			elapsed = (ELAPSED_W'(post_count) << PRE_SHIFT_LONG) | ELAPSED_W'(pre_count);
			period = ELAPSED_ONE << (PRE_SHIFT_LONG + int'(postscale_select_field_i));
		end
		else
		begin
			elapsed = (ELAPSED_W'(post_count) << PRE_SHIFT_SHORT) | ELAPSED_W'(pre_count);
			period = ELAPSED_ONE << (PRE_SHIFT_SHORT + int'(postscale_select_field_i));
		end
	end

	assign window_start = period - (period >> WINDOW_QUARTER_SHIFT);
	assign window_open = window_disable_bit_i || (elapsed >= window_start);
	// early clear only punishes while the watchdog actually runs
	assign early_clear = clear_watchdog_instr_run && wd_enable && !window_open;

	////////////////////////////////////////////////////////////////////////
	// control state

	always_comb
	begin
		r_d = r_q;
		r_d.rst_pulse = 1'b0;
		r_d.wake_pulse = 1'b0;
		r_d.win_open = window_open && wd_enable;
		// enabling the watchdog keeps the oscillator running
		r_d.osc_en = wd_enable;
		if (soft_enable_wr_i)
			r_d.soft_en = soft_enable_wdata_i;
		if (dev_reset_evt)
			r_d.soft_en = 1'b0;
		// set wins over a clear arriving in the same cycle
		if (timeout_flag_clr_i)
			r_d.flag = 1'b0;
		if (timeout)
			r_d.flag = 1'b1;
		unique case (r_q.mode)
			WWDT_RUN:
			begin
				if (timeout || early_clear)
					r_d.rst_pulse = 1'b1;
				else if (power_save_instr_i)
					r_d.mode = WWDT_SAVE;
			end
			WWDT_SAVE:
			begin
				// keeps counting; time-out wakes instead of resetting
				if (timeout)
				begin
					r_d.wake_pulse = 1'b1;
					r_d.mode = WWDT_RUN;
				end
				else if (power_save_exit_i)
					r_d.mode = WWDT_RUN;
			end
		endcase
		if (dev_reset_evt)
			r_d.mode = WWDT_RUN;
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			r_q.mode <= WWDT_RUN;
			r_q.soft_en <= 1'b0;
			r_q.osc_en <= 1'b0;
			r_q.flag <= 1'b0;
			r_q.rst_pulse <= 1'b0;
			r_q.wake_pulse <= 1'b0;
			r_q.win_open <= 1'b0;
		end
		else
			r_q <= r_d;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flops

	assign low_power_rc_osc_en_o = r_q.osc_en;
	assign soft_enable_bit_o = r_q.soft_en;
	assign timeout_flag_o = r_q.flag;
	assign watchdog_reset_o = r_q.rst_pulse;
	assign wake_o = r_q.wake_pulse;
	assign power_save_o = (r_q.mode == WWDT_SAVE);
	assign window_open_o = r_q.win_open;
endmodule : wwdt_top

// *** tb/wwdt_monitor.sv ***
`timescale 1ns/1ps
module wwdt_monitor (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic permanent_enable_bit_i,
	input wire logic window_disable_bit_i,
	input wire logic soft_enable_wr_i,
	input wire logic soft_enable_wdata_i,
	input wire logic timeout_flag_clr_i,
	input wire logic clear_watchdog_instr_i,
	input wire logic power_save_instr_i,
	input wire logic clk_switch_done_i,
	input wire logic device_reset_i,
	input wire logic low_power_rc_osc_en_o,
	input wire logic soft_enable_bit_o,
	input wire logic timeout_flag_o,
	input wire logic watchdog_reset_o,
	input wire logic wake_o,
	input wire logic power_save_o,
	input wire logic window_open_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// window output shows a cycle late what the clear was judged against
	sequence s_early_clear;
		clear_watchdog_instr_i && !power_save_o && (permanent_enable_bit_i || soft_enable_bit_o)
			##1 !window_open_o;
	endsequence
	sequence s_clr_no_set;
		timeout_flag_clr_i ##1 !wake_o && !watchdog_reset_o;
	endsequence
	property p_early; s_early_clear |-> watchdog_reset_o; endproperty
	property p_rst_pulse; watchdog_reset_o |=> !watchdog_reset_o; endproperty
	property p_wake; wake_o |-> timeout_flag_o && !power_save_o && !watchdog_reset_o; endproperty
	property p_save_no_rst; power_save_o |=> !watchdog_reset_o; endproperty
	property p_sticky; timeout_flag_o && !timeout_flag_clr_i |=> timeout_flag_o; endproperty
	property p_flag_clr; s_clr_no_set |-> !timeout_flag_o; endproperty
	property p_perm; permanent_enable_bit_i |=> low_power_rc_osc_en_o; endproperty
	property p_soft_osc; soft_enable_bit_o |=> low_power_rc_osc_en_o; endproperty
	property p_soft_wr;
		soft_enable_wr_i && !device_reset_i && !watchdog_reset_o && !permanent_enable_bit_i
			|=> soft_enable_bit_o == $past(soft_enable_wdata_i);
	endproperty
	property p_dev_rst; device_reset_i |=> !soft_enable_bit_o; endproperty
	// window output is registered from the counts, so allow one extra cycle
	property p_clr_close;
		(clear_watchdog_instr_i || clk_switch_done_i) && !window_disable_bit_i && !power_save_o
			|-> ##2 !window_open_o;
	endproperty
	a_early: assert property (p_early) else $error("early clear gave no reset");
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
	a_wake: assert property (p_wake) else $error("wake without flag");
	a_save_no_rst: assert property (p_save_no_rst) else $error("reset in sleep");
	a_sticky: assert property (p_sticky) else $error("flag cleared itself");
	a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
	a_perm: assert property (p_perm) else $error("oscillator off");
	a_soft_osc: assert property (p_soft_osc) else $error("oscillator not forced");
	a_soft_wr: assert property (p_soft_wr) else $error("soft enable write lost");
	a_dev_rst: assert property (p_dev_rst) else $error("soft enable survived");
	a_clr_close: assert property (p_clr_close) else $error("counts not cleared");
endmodule : wwdt_monitor
bind wwdt_top wwdt_monitor u_wwdt_monitor (
	.clk_sys_i(clk_sys_i),
	.resetn_i(resetn_i),
	.permanent_enable_bit_i(permanent_enable_bit_i),
	.window_disable_bit_i(window_disable_bit_i),
	.soft_enable_wr_i(soft_enable_wr_i),
	.soft_enable_wdata_i(soft_enable_wdata_i),
	.timeout_flag_clr_i(timeout_flag_clr_i),
	.clear_watchdog_instr_i(clear_watchdog_instr_i),
	.power_save_instr_i(power_save_instr_i),
	.clk_switch_done_i(clk_switch_done_i),
	.device_reset_i(device_reset_i),
	.low_power_rc_osc_en_o(low_power_rc_osc_en_o),
	.soft_enable_bit_o(soft_enable_bit_o),
	.timeout_flag_o(timeout_flag_o),
	.watchdog_reset_o(watchdog_reset_o),
	.wake_o(wake_o),
	.power_save_o(power_save_o),
	.window_open_o(window_open_o)
);

// *** tb/windowed_watchdog_timer_bench.sv ***
`timescale 1ns/1ps
module windowed_watchdog_timer_bench;
	import wwdt_pkg::*;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic perm = 1'b0, wdis = 1'b1, pre = 1'b0, swr = 1'b0, swd = 1'b0, fclr = 1'b0;
	logic clrw = 1'b0, psv = 1'b0, pex = 1'b0, csw = 1'b0, dres = 1'b0;
	logic [3:0] post = 4'h0;
	logic osc, sen, flag, wrst, wake, save, wopen;
	int mismatches = 0;
	int checks_done = 0;
	integer seed = 32'hC666B8FA;
	int n;
	int e;
	wwdt_top uut (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .permanent_enable_bit_i(perm),
		.window_disable_bit_i(wdis), .prescale_select_bit_i(pre),
		.postscale_select_field_i(post), .soft_enable_wr_i(swr), .soft_enable_wdata_i(swd),
		.timeout_flag_clr_i(fclr), .clear_watchdog_instr_i(clrw), .power_save_instr_i(psv),
		.power_save_exit_i(pex), .clk_switch_done_i(csw), .device_reset_i(dres),
		.low_power_rc_osc_en_o(osc), .soft_enable_bit_o(sen), .timeout_flag_o(flag),
		.watchdog_reset_o(wrst), .wake_o(wake), .power_save_o(save), .window_open_o(wopen)
	);
	always #4 clk_sys_i = ~clk_sys_i;
	////////////////////////////////////////////////////////////////////////
	// cycles to time-out; first tick offset gives up to one tick of slack
	function automatic int period(input logic p, input int c);
		return int'(OSC_DIV_CYCLES) * (p ? 128 : 32) * (1 << c);
	endfunction : period
	task automatic step(input int k);
		repeat (k) @(negedge clk_sys_i);
	endtask : step
	task automatic chk(input string nm, input logic x, input logic s);
		checks_done++;
		if (s !== x)
		begin
			mismatches++;
			$display("Error %s expected %b seen %b", nm, x, s);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////
	// long enough for one sleep time-out and one window wait
	initial
	begin
		#(8 * 400000);
		mismatches++;
		wrap_up();
	end
	initial
	begin
		step(12);
		chk("reset sen", 1'b0, sen);
		resetn_i = 1'b1;
		swr = 1'b1; swd = 1'b1; step(1); swr = 1'b0; step(1);
		chk("sen", 1'b1, sen);
		chk("osc", 1'b1, osc);
		dres = 1'b1; step(1); dres = 1'b0; step(1);
		chk("sen after reset", 1'b0, sen);
		chk("osc off", 1'b0, osc);
		$display("test soft enable done");
		perm = 1'b1; swr = 1'b1; swd = 1'b0; step(1); swr = 1'b0; step(2);
		chk("osc perm", 1'b1, osc);
		$display("test permanent done");
		wdis = 1'b0;
		// random config and spacing; the window is far off in every case
		repeat (3)
		begin
			pre = 1'($random(seed));
			post = 4'($random(seed));
			dres = 1'b1; step(1); dres = 1'b0;
			step(2 + {$random(seed)} % 2000);
			chk("wopen early", 1'b0, wopen);
			clrw = 1'b1; step(1); clrw = 1'b0;
			chk("early reset", 1'b1, wrst);
			chk("flag early", 1'b0, flag);
			step(2);
		end
		$display("test early clear done");
		pre = 1'b0; post = 4'h0; csw = 1'b1; step(1); csw = 1'b0; n = 0;
		while (wopen !== 1'b1 && n < 200000)
		begin
			step(1);
			n++;
		end
		e = period(1'b0, 0) * 3 / 4;
		chk("window time", 1'b1, n >= e - 3906 && n <= e + 3906);
		clrw = 1'b1; step(1); clrw = 1'b0;
		chk("late clear", 1'b0, wrst);
		// config stays put until the cleared counts reach the window output
		step(2);
		$display("test window done");
		wdis = 1'b1; psv = 1'b1; step(1); psv = 1'b0;
		chk("save", 1'b1, save);
		pex = 1'b1; step(1); pex = 1'b0;
		chk("save exit", 1'b0, save);
		psv = 1'b1; step(1); psv = 1'b0; n = 0;
		while (wake !== 1'b1 && n < 200000)
		begin
			step(1);
			n++;
		end
		e = period(1'b0, 0);
		chk("wake time", 1'b1, n >= e - 3906 && n <= e + 3906);
		chk("no reset", 1'b0, wrst);
		chk("run after wake", 1'b0, save);
		chk("flag", 1'b1, flag);
		step(3);
		chk("flag sticky", 1'b1, flag);
		fclr = 1'b1; step(1); fclr = 1'b0; step(1);
		chk("flag clear", 1'b0, flag);
		$display("test sleep done");
		wrap_up();
	end
endmodule : windowed_watchdog_timer_bench
